// ### internal_clock_loop_settling_bench.sv
// Self-checking bench for the loop correction control block.
`timescale 1ns/10ps
module internal_clock_loop_settling_bench;
  logic                sys_clk = 1'b0;   // 100 MHz system clock.
  logic                reset_n = 1'b0;   // Active low reset.
  logic                hsel    = 1'b0;   // Bus select.
  logic [31:0]         haddr   = '0;     // Bus byte address.
  logic [1:0]          htrans  = 2'b00;  // Bus transfer kind.
  logic                hwrite  = 1'b0;   // Bus direction.
  logic [31:0]         hwdata  = '0;     // Bus write data.
  wire logic           hrdy;             // Slave ready is the bus ready.
  logic                hresp;            // Slave response.
  logic [31:0]         hrdata;           // Slave read data.
  logic                base    = 1'b0;   // Low frequency base clock.
  internal_clock_out_pkg::internal_clock_out_err_t cmp_err = '0;     // Comparator report.
  logic                m_fault = 1'b1;   // Monitor fault input.
  logic                x_stbl  = 1'b1;   // External clock stable input.
  logic                gen_on, mon_on, irq_en, sel, ext_on, stbl, irq;
  logic [3:0]          div;
  logic [7:0]          stg;
  logic [6:0]          mult;
  logic [31:0]         rd;               // Last read value.
  int                  err_total   = 0;
  int                  check_count = 0;
  int                  i;
  internal_clock_out_loop_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .low_freq_base_clock(base), .cmp_err(cmp_err),
    .monitor_fault_flag(m_fault), .external_clock_stable(x_stbl),
    .internal_generator_on(gen_on), .clock_monitor_on(mon_on),
    .monitor_irq_enable(irq_en), .clock_select(sel),
    .external_generator_on(ext_on), .clock_stable_flag(stbl),
    .osc_divider_code(div), .osc_stage_code(stg), .mult_factor(mult),
    .irq(irq));
  // Free running clock, 10 ns period.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Compare one value; case equality so an unknown bit never matches a known one.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single AHB-Lite transfer; an idle cycle follows every transfer.
  task automatic ahb(input logic [7:0] idx, input logic w,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge sys_clk);
    while (hrdy !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hrdy !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    @(posedge sys_clk);
  endtask : ahb
  // Read a register and compare it.
  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [31:0] e);
    ahb(idx, 1'b0, 32'h0);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk
  // One correction: four base rises; no move before the fourth.
  task automatic step(input internal_clock_out_pkg::internal_clock_out_band_t b, input logic up,
                      input logic [11:0] e);
    logic [11:0] was;
    was = {div, stg};
    cmp_err <= {b, up};
    for (int k = 0; k < 4; k++) begin
      repeat (3) @(posedge sys_clk);
      if (k == 3) chk("code early", {20'h0, was}, {20'h0, div, stg});
      base <= 1'b1;
      repeat (3) @(posedge sys_clk);
      base <= 1'b0;
    end
    @(posedge sys_clk);
    chk("code", {20'h0, e}, {20'h0, div, stg});
  endtask : step
  // Reset readings, bus reach and refusal of code writes while running.
  task automatic t_reset();
    rchk("ctrl", 8'h36, 32'h49);
    rchk("mult", 8'h37, 32'h15);
    rchk("stage", 8'h3a, 32'h80);
    rchk("unmapped", 8'h10, 32'h0);
    ahb(8'h37, 1'b1, 32'h2a);
    chk("mult out", 32'h2a, {25'h0, mult});
    ahb(8'h39, 1'b1, 32'h5);
    rchk("div on", 8'h39, 32'h0);
  endtask : t_reset
  // Generator off: forced readings, preload, saturation and restart.
  task automatic t_preload();
    ahb(8'h36, 1'b1, 32'ha0);
    rchk("ctrl off", 8'h36, 32'h13);
    chk("outs off", 32'h3,
        {27'h0, gen_on, mon_on, irq_en, sel, ext_on});
    ahb(8'h39, 1'b1, 32'hc);
    rchk("div raw", 8'h39, 32'hc);
    chk("div sat", 32'h9, {28'h0, div});
    ahb(8'h39, 1'b1, 32'h2);
    ahb(8'h3a, 1'b1, 32'hf0);
    ahb(8'h36, 1'b1, 32'h08);
    chk("restart", 32'h2f0, {20'h0, div, stg});
  endtask : t_preload
  // Band steps, stable flag and its interrupt.
  task automatic t_settle();
    step(internal_clock_out_pkg::BAND_COARSE, 1'b1, 12'h310);
    step(internal_clock_out_pkg::BAND_MEDIUM, 1'b0, 12'h308);
    chk("not stable", 32'h0, {31'h0, stbl});
    step(internal_clock_out_pkg::BAND_MIN, 1'b1, 12'h309);
    chk("stable", 32'h1, {31'h0, stbl});
    step(internal_clock_out_pkg::BAND_LOCK, 1'b0, 12'h309);
    rchk("istat", 8'h3e, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(8'h3f, 1'b1, 32'h1);
    chk("irq on", 32'h1, {31'h0, irq});
    ahb(8'h3e, 1'b1, 32'h1);
    chk("irq clr", 32'h0, {31'h0, irq});
    rchk("istat clr", 8'h3e, 32'h0);
    // Eight coarse steps carry once into the divider: period doubles.
    for (i = 0; i < 8; i++) begin
      step(internal_clock_out_pkg::BAND_COARSE, 1'b1, 12'h309 + 12'(32 * (i + 1)));
    end
    chk("doubled", 32'h409, {20'h0, div, stg});
  endtask : t_settle
  // Stepping past the ceiling saturates and raises the limit event.
  task automatic t_limit();
    ahb(8'h36, 1'b1, 32'h00);
    // The state falls one edge after the enable does; let it settle.
    @(posedge sys_clk);
    chk("stable off", 32'h0, {31'h0, stbl});
    ahb(8'h39, 1'b1, 32'h9);
    ahb(8'h3a, 1'b1, 32'hf0);
    ahb(8'h36, 1'b1, 32'h08);
    step(internal_clock_out_pkg::BAND_COARSE, 1'b1, 12'h9ff);
    rchk("istat lim", 8'h3e, 32'h2);
    ahb(8'h3f, 1'b1, 32'h2);
    chk("irq lim", 32'h1, {31'h0, irq});
  endtask : t_limit
  // Verdict; the only place the run ends.
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // Main sequence.
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_preload();
    t_settle();
    t_limit();
    conclude();
  end
  // The run needs a few hundred cycles; this cuts a hang short.
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule : internal_clock_loop_settling_bench
bind internal_clock_out_loop_ctrl internal_clock_out_loop_ctrl_chk u_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
  .low_freq_base_clock(low_freq_base_clock), .cmp_err(cmp_err),
  .internal_generator_on(internal_generator_on),
  .clock_monitor_on(clock_monitor_on),
  .monitor_irq_enable(monitor_irq_enable), .clock_select(clock_select),
  .external_generator_on(external_generator_on),
  .clock_stable_flag(clock_stable_flag),
  .osc_divider_code(osc_divider_code), .osc_stage_code(osc_stage_code));

// ### internal_clock_out_loop_ctrl.sv
// Loop filter correction control with an AHB-Lite register slave.
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
// Overview of operation
// RULE_01: Coarse steps above 15 percent, eight double period.
// RULE_02: Eight coarse steps sum about eleven fastest.
// RULE_03: Medium band steps 1.61 to 2.94 percent.
// RULE_04: At most eight medium steps reach 5 percent.
// RULE_05: Each correction spans four base clock periods.
// RULE_06: Stable flag set when error below 5 percent.
// RULE_07: Below 5 percent only minimum single steps.
// RULE_08: At most 24 minimum steps, 32 total.
// RULE_09: Code writes accepted only while generator off.
// RULE_10: Restart begins at last written codes.
// RULE_11: Period tracks two-power divider times stage.
// RULE_12: Generator off forces fixed control readings.
// RULE_13: Software shifts divider for power-of-two ratios.
// RULE_14: Software halves stage above 255, bumps divider.
// RULE_15: Software keeps divider 0 to 9 only.
// RULE_16: Divider saturates at nine, divide by 512.
// RULE_17: Divider moves only by stage carry or borrow.
// RULE_18: Target is multiply factor times base clock.
// RULE_19: Step size from band, direction reduces error.
module internal_clock_out_loop_ctrl (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic             low_freq_base_clock,
  input  wire internal_clock_out_pkg::internal_clock_out_err_t cmp_err,
  input  wire logic             monitor_fault_flag,
  input  wire logic             external_clock_stable,
  output logic                  internal_generator_on,
  output logic                  clock_monitor_on,
  output logic                  monitor_irq_enable,
  output logic                  clock_select,
  output logic                  external_generator_on,
  output logic                  clock_stable_flag,
  output logic [3:0]            osc_divider_code,
  output logic [7:0]            osc_stage_code,
  output logic [6:0]            mult_factor,
  output logic                  irq
);

  // Filter states: idle while off, settling, then stable.
  typedef enum logic [1:0] {
    ST_OFF, ST_SETTLE, ST_STABLE
  } internal_clock_out_state_t;

  // Width of the event status and mask, taken from the package.
  localparam int unsigned IRQ_W = internal_clock_out_pkg::IRQ_W;

  internal_clock_out_state_t            state_q;     // Filter state.
  logic                   ph_wr_q;     // Data phase is a write.
  logic [7:0]             ph_idx_q;    // Word index of data phase.
  logic                   ph_act_q;    // A data phase is pending.
  logic                   take;        // Address phase accepted.
  logic [7:0]             a_idx;       // Word index of address phase.
  logic                   wr_ctrl;     // Write strobes, data phase.
  logic                   wr_mult;
  logic                   wr_div;
  logic                   wr_stage;
  logic                   wr_istat;
  logic                   wr_imask;
  logic                   gen_on_q;    // Internal generator enable.
  logic                   mon_q;       // Clock monitor enable.
  logic                   irqen_q;     // Monitor interrupt enable.
  logic                   sel_q;       // Clock select.
  logic                   exton_q;     // External generator enable.
  logic [6:0]             mult_q;      // Multiply factor.
  logic [3:0]             div_q;       // Divider code as stored.
  logic [7:0]             stage_q;     // Stage code.
  logic [3:0]             div_eff;     // Divider code after ceiling.
  logic [IRQ_W-1:0]       istat_q;     // Sticky event bits.
  logic [IRQ_W-1:0]       imask_q;     // Event enables.
  logic [IRQ_W-1:0]       ev;          // Event pulses this cycle.
  logic                   base_q;      // Base clock last sample.
  logic                   base_rise;   // Base clock rising edge.
  logic [2:0]             edge_cnt_q;  // Base edges in this correction.
  logic                   corr;        // Correction strobe.
  logic [7:0]             step;        // Chosen stage step.
  logic [12:0]            sum;         // Code after the step.
  logic                   over;        // Step ran past the ceiling.
  logic                   under;       // Step ran below zero.
  logic [7:0]             ctrl_rd;     // Control register read view.
  logic [31:0]            rd_d;        // Next read data.

  // Package names used throughout.
  localparam internal_clock_out_pkg::internal_clock_out_band_t B_COARSE = internal_clock_out_pkg::BAND_COARSE;
  localparam internal_clock_out_pkg::internal_clock_out_band_t B_MEDIUM = internal_clock_out_pkg::BAND_MEDIUM;
  localparam internal_clock_out_pkg::internal_clock_out_band_t B_MIN    = internal_clock_out_pkg::BAND_MIN;

  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase decode; only word index bits matter.
  assign take  = hsel & htrans[1] & hready;
  assign a_idx = haddr[9:2];

  // Latch the address phase for the following data phase.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_act_q <= 1'b0;
      ph_wr_q  <= 1'b0;
      ph_idx_q <= 8'h00;
    end else if (hready) begin
      ph_act_q <= take;
      ph_wr_q  <= take & hwrite;
      ph_idx_q <= a_idx;
    end
  end

  // Write strobes act in the data phase, when hwdata stands.
  always_comb begin
    wr_ctrl  = ph_wr_q & (ph_idx_q == internal_clock_out_pkg::IDX_CTRL);
    wr_mult  = ph_wr_q & (ph_idx_q == internal_clock_out_pkg::IDX_MULT);
    wr_div   = ph_wr_q & (ph_idx_q == internal_clock_out_pkg::IDX_DIV);
    wr_stage = ph_wr_q & (ph_idx_q == internal_clock_out_pkg::IDX_STAGE);
    wr_istat = ph_wr_q & (ph_idx_q == internal_clock_out_pkg::IDX_ISTAT);
    wr_imask = ph_wr_q & (ph_idx_q == internal_clock_out_pkg::IDX_IMASK);
  end

  // Control bits. With the generator off, monitor bits are held
  // clear and select and external enable held set, so software
  // can leave the system without a running source for one cycle at most.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_on_q <= internal_clock_out_pkg::GENON_RST;
      mon_q    <= 1'b0;
      irqen_q  <= 1'b0;
      sel_q    <= 1'b0;
      exton_q  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        gen_on_q <= hwdata[internal_clock_out_pkg::C_GENON];
        mon_q    <= hwdata[internal_clock_out_pkg::C_MON];
        irqen_q  <= hwdata[internal_clock_out_pkg::C_IRQEN];
        sel_q    <= hwdata[internal_clock_out_pkg::C_SEL];
        exton_q  <= hwdata[internal_clock_out_pkg::C_EXTON];
      end
      if (!gen_on_q) begin
        mon_q   <= 1'b0; // RULE_12
        irqen_q <= 1'b0; // RULE_12
        sel_q   <= 1'b1; // RULE_12
        exton_q <= 1'b1; // RULE_12
      end
    end
  end

  // Multiply factor sets the comparator's target frequency.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mult_q <= internal_clock_out_pkg::MULT_RST;
    end else if (wr_mult) begin
      mult_q <= hwdata[6:0]; // RULE_18
    end
  end

  // Codes above nine act as nine.
  assign div_eff = (div_q > internal_clock_out_pkg::DIV_MAX) ?
                   internal_clock_out_pkg::DIV_MAX : div_q; // RULE_16

  // Base clock is sampled as a synchronous level.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= 1'b0;
    end else begin
      base_q <= low_freq_base_clock;
    end
  end

  assign base_rise = low_freq_base_clock & ~base_q;

  // Count base edges; every fourth one ends a correction.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_cnt_q <= 3'h0;
    end else if (!gen_on_q) begin
      edge_cnt_q <= 3'h0;
    end else if (base_rise) begin
      if (edge_cnt_q == internal_clock_out_pkg::BASE_EDGES - 3'h1) begin
        edge_cnt_q <= 3'h0; // RULE_05
      end else begin
        edge_cnt_q <= edge_cnt_q + 3'h1;
      end
    end
  end

  assign corr = gen_on_q & base_rise &
    (edge_cnt_q == internal_clock_out_pkg::BASE_EDGES - 3'h1); // RULE_05

  // Step size per band. A coarse step flips stage bit 5, so eight
  // of them carry once into the divider and double the period; the
  // medium step is eight minimum steps, the minimum is one.
  always_comb begin
    case (cmp_err.band)
      B_COARSE: step = internal_clock_out_pkg::STEP_COARSE; // RULE_01 RULE_02 RULE_19
      B_MEDIUM: step = internal_clock_out_pkg::STEP_MEDIUM; // RULE_03 RULE_04 RULE_19
      B_MIN:    step = internal_clock_out_pkg::STEP_MIN;    // RULE_07 RULE_08 RULE_19
      default:  step = 8'h00;
    endcase
  end

  // Divider and stage form one code, so the divider only moves by
  // a stage carry or borrow; period goes as 2^divider times stage.
  always_comb begin
    if (cmp_err.longer) begin
      sum = {1'b0, div_eff, stage_q} + {5'h00, step}; // RULE_17 RULE_19
    end else begin
      sum = {1'b0, div_eff, stage_q} - {5'h00, step}; // RULE_17 RULE_19
    end
    under = ~cmp_err.longer & sum[12];
    over  = cmp_err.longer & (sum[11:8] > internal_clock_out_pkg::DIV_MAX);
  end

  // Code registers: software writes only while off, the filter
  // steps only while on, so the two never collide. Codes survive
  // disable, so a restart begins where software left them.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q   <= internal_clock_out_pkg::DIV_RST;
      stage_q <= internal_clock_out_pkg::STAGE_RST;
    end else if (!gen_on_q) begin
      if (wr_div) begin
        div_q <= hwdata[3:0]; // RULE_09 RULE_10
      end
      if (wr_stage) begin
        stage_q <= hwdata[7:0]; // RULE_09 RULE_10
      end
    end else if (corr && step != 8'h00) begin
      if (over) begin
        div_q   <= internal_clock_out_pkg::DIV_MAX; // RULE_16
        stage_q <= 8'hff;
      end else if (under) begin
        div_q   <= 4'h0;
        stage_q <= 8'h00;
      end else begin
        div_q   <= sum[11:8]; // RULE_11 RULE_17
        stage_q <= sum[7:0];  // RULE_11
      end
    end
  end

  // Stable once the comparator first reports under 5 percent; it
  // stays set through later band noise until the generator stops.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (gen_on_q) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (!gen_on_q) begin
            state_q <= ST_OFF;
          end else if (corr && (cmp_err.band == B_MIN ||
                       cmp_err.band == internal_clock_out_pkg::BAND_LOCK)) begin
            state_q <= ST_STABLE; // RULE_06
          end
        end
        ST_STABLE: begin
          if (!gen_on_q) begin
            state_q <= ST_OFF; // RULE_12
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // Event pulses: stable reached, and code pinned at a limit.
  always_comb begin
    ev = '0;
    ev[internal_clock_out_pkg::IRQ_STABLE] = (state_q == ST_SETTLE) & gen_on_q &
      corr & (cmp_err.band == B_MIN ||
              cmp_err.band == internal_clock_out_pkg::BAND_LOCK);
    ev[internal_clock_out_pkg::IRQ_LIMIT] = gen_on_q & corr & (step != 8'h00) &
      (over | under);
  end

  // Sticky status, write one to clear; a new event wins the clear.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      istat_q <= '0;
    end else begin
      istat_q <= (istat_q & ~(wr_istat ? hwdata[IRQ_W-1:0] : '0)) | ev;
    end
  end

  // Interrupt mask, a one enables the matching status bit.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      imask_q <= '0;
    end else if (wr_imask) begin
      imask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // Control read view; the monitor flag reads clear while off.
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[internal_clock_out_pkg::C_IRQEN] = irqen_q;
    ctrl_rd[internal_clock_out_pkg::C_MFLT]  = monitor_fault_flag & gen_on_q; // RULE_12
    ctrl_rd[internal_clock_out_pkg::C_MON]   = mon_q;
    ctrl_rd[internal_clock_out_pkg::C_SEL]   = sel_q;
    ctrl_rd[internal_clock_out_pkg::C_GENON] = gen_on_q;
    ctrl_rd[internal_clock_out_pkg::C_STBL]  = (state_q == ST_STABLE);
    ctrl_rd[internal_clock_out_pkg::C_EXTON] = exton_q;
    ctrl_rd[internal_clock_out_pkg::C_EXTST] = external_clock_stable |
                                 ~gen_on_q; // RULE_12
  end

  // Read mux, selected in the address phase; unmapped reads zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (a_idx)
      internal_clock_out_pkg::IDX_CTRL:  rd_d[7:0] = ctrl_rd;
      internal_clock_out_pkg::IDX_MULT:  rd_d[6:0] = mult_q;
      internal_clock_out_pkg::IDX_DIV:   rd_d[3:0] = div_q;
      internal_clock_out_pkg::IDX_STAGE: rd_d[7:0] = stage_q;
      internal_clock_out_pkg::IDX_ISTAT: rd_d[IRQ_W-1:0] = istat_q;
      internal_clock_out_pkg::IDX_IMASK: rd_d[IRQ_W-1:0] = imask_q;
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  // Read data is registered so it stands for the whole data phase.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Outputs toward the oscillator, comparator and clock logic.
  assign internal_generator_on = gen_on_q;
  assign clock_monitor_on      = mon_q;
  assign monitor_irq_enable    = irqen_q;
  assign clock_select          = sel_q;
  assign external_generator_on = exton_q;
  assign clock_stable_flag     = (state_q == ST_STABLE); // RULE_06
  assign osc_divider_code      = div_eff;
  assign osc_stage_code        = stage_q;
  assign mult_factor           = mult_q; // RULE_18
  assign irq                   = |(istat_q & imask_q);

  // Transfer size is fixed to words; hsize is accepted and unused.
  logic unused_size;
  assign unused_size = ^hsize;

endmodule : internal_clock_out_loop_ctrl

// ### internal_clock_out_loop_ctrl_chk.sv
// Concurrent checks on the ports of the loop correction control block.
`timescale 1ns/10ps
module internal_clock_out_loop_ctrl_chk (
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic                low_freq_base_clock,
  input wire internal_clock_out_pkg::internal_clock_out_err_t cmp_err,
  input wire logic                internal_generator_on,
  input wire logic                clock_monitor_on,
  input wire logic                monitor_irq_enable,
  input wire logic                clock_select,
  input wire logic                external_generator_on,
  input wire logic                clock_stable_flag,
  input wire logic [3:0]          osc_divider_code,
  input wire logic [7:0]          osc_stage_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [11:0]         prev_q;  // Combined code one cycle back.
  logic                gen_q;   // Generator enable one cycle back.
  internal_clock_out_pkg::internal_clock_out_err_t err_q;   // Comparator report one cycle back.
  logic [11:0]         cur;     // Combined divider and stage code.
  logic [11:0]         diff;    // Signed code change over one cycle.
  logic                moved;   // Code moved while the loop was running.
  assign cur   = {osc_divider_code, osc_stage_code};
  assign diff  = cur - prev_q;
  assign moved = internal_generator_on && gen_q && (cur != prev_q);
  // History registers; reset values match the design's reset codes.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 12'h080;
      gen_q  <= 1'b1;
      err_q  <= '0;
    end else begin
      prev_q <= cur;
      gen_q  <= internal_generator_on;
      err_q  <= cmp_err;
    end
  end
  // Two samples with the generator off, so forced values have landed.
  sequence s_off2;
    !internal_generator_on ##1 !internal_generator_on;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_div_sat: assert property (osc_divider_code <= 4'h9)
    else $error("divider code above ceiling");
  a_off_forces: assert property (s_off2 |-> !clock_monitor_on &&
      !monitor_irq_enable && clock_select && external_generator_on)
    else $error("control outputs not forced while generator off");
  a_stable_off: assert property (s_off2 |-> !clock_stable_flag)
    else $error("stable flag set while generator off");
  a_code_at_base: assert property (moved |->
      $past(low_freq_base_clock) || $past(low_freq_base_clock, 2))
    else $error("code moved away from a base clock edge");
  a_step_size: assert property (moved |-> (diff inside {12'h020, 12'hfe0,
      12'h008, 12'hff8, 12'h001, 12'hfff}) || cur == 12'h9ff ||
      cur == 12'h000)
    else $error("code moved by a step outside the band sizes");
  a_dir_longer: assert property (moved |->
      ((cur > prev_q) == err_q.longer))
    else $error("code moved against the wanted direction");
  a_stable_band: assert property ($rose(clock_stable_flag) |->
      internal_generator_on && (err_q.band inside
      {internal_clock_out_pkg::BAND_MIN, internal_clock_out_pkg::BAND_LOCK}))
    else $error("stable flag rose outside the fine band");
endmodule : internal_clock_out_loop_ctrl_chk

// ### internal_clock_out_pkg.sv
// Package of constants and types for the internal clock loop control.
package internal_clock_out_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_CTRL  = 8'h36;
  localparam logic [7:0] IDX_MULT  = 8'h37;
  localparam logic [7:0] IDX_DIV   = 8'h39;
  localparam logic [7:0] IDX_STAGE = 8'h3a;
  localparam logic [7:0] IDX_ISTAT = 8'h3e;
  localparam logic [7:0] IDX_IMASK = 8'h3f;
  // Control register bit positions.
  localparam int unsigned C_IRQEN = 7;
  localparam int unsigned C_MFLT  = 6;
  localparam int unsigned C_MON   = 5;
  localparam int unsigned C_SEL   = 4;
  localparam int unsigned C_GENON = 3;
  localparam int unsigned C_STBL  = 2;
  localparam int unsigned C_EXTON = 1;
  localparam int unsigned C_EXTST = 0;
  // Reset values.
  localparam logic       GENON_RST = 1'h1;
  localparam logic [6:0] MULT_RST  = 7'h15;
  localparam logic [3:0] DIV_RST   = 4'h0;
  localparam logic [7:0] STAGE_RST = 8'h80;
  // Divider code ceiling, a divide by 512.
  localparam logic [3:0] DIV_MAX   = 4'h9;
  // Stage steps for the three error bands.
  localparam logic [7:0] STEP_COARSE = 8'h20;
  localparam logic [7:0] STEP_MEDIUM = 8'h08;
  localparam logic [7:0] STEP_MIN    = 8'h01;
  // Base clock rising edges per correction.
  localparam logic [2:0] BASE_EDGES  = 3'h4;
  // Interrupt status bits.
  localparam int unsigned IRQ_W      = 2;
  localparam int unsigned IRQ_STABLE = 0;
  localparam int unsigned IRQ_LIMIT  = 1;
  // Error band reported by the frequency comparator.
  typedef enum logic [1:0] {
    BAND_COARSE, BAND_MEDIUM, BAND_MIN, BAND_LOCK
  } internal_clock_out_band_t;
  // Comparator report: band and wanted direction.
  typedef struct packed {
    internal_clock_out_band_t band;
    logic       longer;
  } internal_clock_out_err_t;
endpackage : internal_clock_out_pkg
